// file: twi_pkg.sv
// Shared constants for the two-wire bus ends
package twi_pkg;
	// Device type code; value is arbitrary
	localparam logic [3:0] TYPE_CODE       = 4'h5;
	localparam int         BYTE_BITS       = 8;
	localparam logic [3:0] ACK_SLOT        = 4'h8;
	localparam logic [3:0] BIT_CNT_RESET   = 4'h0;
	localparam logic [7:0] BYTE_RESET      = 8'h00;
	// Link clock timing for the master's divider
	localparam int         CLK_HZ          = 20_000_000;
	localparam int         SCL_STD_HZ      = 100_000;
	localparam int         SCL_FAST_HZ     = 400_000;
	localparam int         QTR_STD_CYC     = CLK_HZ / (SCL_STD_HZ * 4);
	localparam int         QTR_FAST_CYC    = CLK_HZ / (SCL_FAST_HZ * 4);
	localparam logic [7:0] QTR_STD         = QTR_STD_CYC[7:0];
	localparam logic [7:0] QTR_FAST        = QTR_FAST_CYC[7:0];
	localparam logic [1:0] SYNC_RESET      = 2'h3;
endpackage : twi_pkg

// file: twi_if.sv
// Open-drain two-wire bus joining master and slave ends
`timescale 1ns/100ps
`default_nettype none
interface twi_if;
	logic scl_m_oe;
	logic sda_m_oe;
	logic sda_s_oe;
	logic scl_s_oe;
	logic scl;
	logic sda;
	// Wired-and with pull-ups
	assign scl = ~(scl_m_oe | scl_s_oe);
	assign sda = ~(sda_m_oe | sda_s_oe);
	modport slave (input scl, input sda, output sda_s_oe, output scl_s_oe);
	modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface : twi_if
`default_nettype wire

// file: twi_slave.sv
// Slave end of the two-wire bus: START/STOP, addressing, receive, transmit
// Operation
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - Data changes only while SCL low
// - Master starts only on idle bus
// - Eight data bits plus acknowledge clock
// - Master supplies the acknowledge clock
// - Acknowledger holds SDA low whole high
// - After master NACK slave releases SDA
// - Write: address then data, all acknowledged
// - Master acknowledges all but last byte
// - STOP or repeated START ends transfer
// - Any byte count, master decides
// - Works at 100 and 400 kHz
// - Slave only, open-drain, no clocking
// - Control byte: type, select, direction
// - Select bits compared with strap pins
// - Direction one reads, zero writes
// - Acknowledge only on full match
// - Receive acks every byte, hardware match
// - Read: ack control, then shift out
`timescale 1ns/100ps
`default_nettype none
module twi_slave (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       select_strap_high_i,
	input  wire logic       select_strap_mid_i,
	input  wire logic       select_strap_low_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_take_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_valid_o,
	output logic            start_o,
	output logic            stop_o,
	output logic            read_mode_o,
	twi_if.slave            bus
);
	import twi_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CTRL = 3'b001,
		ST_RX   = 3'b011,
		ST_TX   = 3'b010,
		ST_IGN  = 3'b110
	} state_t;

	typedef struct packed {
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		logic       scl_p;
		logic       sda_p;
		state_t     st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] txs;
		logic       oe;
		logic       ackd;
		logic       rd;
		logic [7:0] rxd;
		logic       rxv;
		logic       take;
		logic       sta;
		logic       sto;
		logic       skip;     // Clock fall closing START still due
		logic [5:0] strap_sy; // Two-flop strap synchroniser
	} slv_t;

	slv_t q, d;
	logic scl, sda, rise, fall, start, stop;

	// Address match on the control byte
	// type then select fields
	function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] s);
		addr_hit = (b[7:4] == TYPE_CODE) && (b[3:1] == s);
	endfunction : addr_hit

	// Next state
	always_comb begin
		d        = q;
		d.scl_sy = {q.scl_sy[0], bus.scl};
		d.sda_sy = {q.sda_sy[0], bus.sda};
		d.strap_sy = {q.strap_sy[2:0], select_strap_high_i, select_strap_mid_i, select_strap_low_i};
		scl      = q.scl_sy[1];
		sda      = q.sda_sy[1];
		d.scl_p  = scl;
		d.sda_p  = sda;
		rise     = scl & ~q.scl_p;
		fall     = ~scl & q.scl_p;
		start    = scl & q.scl_p & q.sda_p & ~sda;
		stop     = scl & q.scl_p & ~q.sda_p & sda;
		d.rxv    = 1'b0;
		d.take   = 1'b0;
		d.sta    = start;
		d.sto    = stop;
		if (start) begin
			d.st  = ST_CTRL;
			d.cnt = BIT_CNT_RESET;
			d.oe  = 1'b0;
			d.rd  = 1'b0;
			d.skip = 1'b1;
		end else if (stop) begin
			d.st  = ST_IDLE;
			d.cnt = BIT_CNT_RESET;
			d.oe  = 1'b0;
			d.skip = 1'b0;
		end else if (q.skip) begin
			// START's own clock fall is no bit
			if (fall) begin
				d.skip = 1'b0;
			end
		end else if (q.st != ST_IDLE && q.st != ST_IGN) begin
			// sample data on the rising clock
			if (rise && q.cnt < ACK_SLOT) begin
				d.sh = {q.sh[6:0], sda};
			end
			if (rise && q.cnt == ACK_SLOT) begin
				d.ackd = ~sda;
			end
			// drive changes on the falling clock; nine clocks per byte
			if (fall) begin
				d.cnt = (q.cnt == ACK_SLOT) ? BIT_CNT_RESET : q.cnt + 4'h1;
				d.oe  = 1'b0;
				if (q.cnt == 4'h7) begin
					case (q.st)
						ST_CTRL: begin
							// select bits; ack only on match
							if (addr_hit(q.sh, q.strap_sy[5:3])) begin
								d.oe = 1'b1;
								d.rd = q.sh[0];
							end else begin
								d.st = ST_IGN;
							end
						end
						ST_RX: begin
							d.oe    = 1'b1;
							d.rxd   = q.sh;
							d.rxv   = 1'b1;
						end
						default: begin
							d.oe = 1'b0;
						end
					endcase
				end else if (q.cnt == ACK_SLOT) begin
					case (q.st)
						ST_CTRL: begin
							d.st = q.rd ? ST_TX : ST_RX;
							if (q.rd) begin
								d.txs  = {tx_data_i[6:0], 1'b0};
								d.oe   = ~tx_data_i[7];
								d.take = 1'b1;
							end
						end
						ST_TX: begin
							if (q.ackd) begin
								d.txs  = {tx_data_i[6:0], 1'b0};
								d.oe   = ~tx_data_i[7];
								d.take = 1'b1;
							end else begin
								d.st = ST_IGN;
							end
						end
						default: begin
							d.oe = 1'b0;
						end
					endcase
				end else if (q.st == ST_TX) begin
					d.oe  = ~q.txs[7];
					d.txs = {q.txs[6:0], 1'b0};
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q        <= '0;
			q.scl_sy <= SYNC_RESET;
			q.sda_sy <= SYNC_RESET;
			q.scl_p  <= 1'b1;
			q.sda_p  <= 1'b1;
			q.st     <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

	assign bus.scl_s_oe = 1'b0;
	assign bus.sda_s_oe = q.oe;
	assign rx_data_o    = q.rxd;
	assign rx_valid_o   = q.rxv;
	assign tx_take_o    = q.take;
	assign start_o      = q.sta;
	assign stop_o       = q.sto;
	assign read_mode_o  = q.rd;
endmodule : twi_slave
`default_nettype wire

// file: twi_master.sv
// Master end of the two-wire bus: one byte per command
`timescale 1ns/100ps
`default_nettype none
module twi_master (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       fast_i,
	input  wire logic       cmd_valid_i,
	input  wire logic       cmd_start_i,
	input  wire logic       cmd_stop_i,
	input  wire logic       cmd_read_i,
	input  wire logic       cmd_ack_i,
	input  wire logic [7:0] cmd_data_i,
	output logic            cmd_ready_o,
	output logic            done_o,
	output logic [7:0]      rd_data_o,
	output logic            ack_seen_o,
	twi_if.master           bus
);
	import twi_pkg::*;

	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_STA  = 3'b001,
		M_BIT  = 3'b011,
		M_STO  = 3'b010,
		M_DONE = 3'b110
	} mstate_t;

	typedef struct packed {
		logic [1:0] sda_sy;
		mstate_t    st;
		logic [7:0] tq;
		logic [1:0] ph;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic       rd;
		logic       ackm;
		logic       sto;
		logic       scl_oe;
		logic       sda_oe;
		logic [7:0] rdd;
		logic       acks;
		logic       done;
	} mst_t;

	mst_t q, d;
	logic tick;
	logic sda;

	// Quarter-period divider and byte sequencer
	always_comb begin
		d        = q;
		d.sda_sy = {q.sda_sy[0], bus.sda};
		sda      = q.sda_sy[1];
		d.done   = 1'b0;
		tick     = (q.tq == 8'h00);
		d.tq     = tick ? (fast_i ? QTR_FAST : QTR_STD) - 8'h01 : q.tq - 8'h01;
		if (q.st == M_IDLE) begin
			d.tq = BYTE_RESET;
		end
		case (q.st)
			M_IDLE: begin
				if (cmd_valid_i && (!cmd_start_i || sda)) begin
					d.sh   = cmd_data_i;
					d.rd   = cmd_read_i;
					d.ackm = cmd_ack_i;
					d.sto  = cmd_stop_i;
					d.cnt  = BIT_CNT_RESET;
					d.ph   = 2'h0;
					d.st   = cmd_start_i ? M_STA : M_BIT;
				end
			end
			M_STA: if (tick) begin
				// SDA low with SCL high, then SCL low
				d.ph = q.ph + 2'h1;
				case (q.ph)
					2'h0: begin d.sda_oe = 1'b0; d.scl_oe = 1'b0; end
					2'h1: d.sda_oe = 1'b1;
					2'h2: d.scl_oe = 1'b1;
					default: begin d.st = M_BIT; d.ph = 2'h0; end
				endcase
			end
			M_BIT: if (tick) begin
				// nine clocks, change data while low
				d.ph = q.ph + 2'h1;
				case (q.ph)
					2'h0: begin
						if (q.cnt < ACK_SLOT) begin
							d.sda_oe = ~q.rd & ~q.sh[7];
						end else begin
							d.sda_oe = q.rd & q.ackm;
						end
					end
					2'h1: d.scl_oe = 1'b0;
					2'h2: begin
						if (q.cnt < ACK_SLOT) begin
							d.sh = {q.sh[6:0], sda};
						end else begin
							d.acks = ~sda;
						end
					end
					default: begin
						d.scl_oe = 1'b1;
						d.cnt    = q.cnt + 4'h1;
						if (q.cnt == ACK_SLOT) begin
							d.sda_oe = 1'b0;
							d.rdd    = q.sh;
							d.st     = q.sto ? M_STO : M_DONE;
						end
					end
				endcase
			end
			M_STO: if (tick) begin
				d.ph = q.ph + 2'h1;
				case (q.ph)
					2'h0: d.sda_oe = 1'b1;
					2'h1: d.scl_oe = 1'b0;
					2'h2: d.sda_oe = 1'b0;
					default: d.st = M_DONE;
				endcase
			end
			M_DONE: begin
				d.done = 1'b1;
				d.st   = M_IDLE;
			end
			default: d.st = M_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q        <= '0;
			q.sda_sy <= SYNC_RESET;
			q.st     <= M_IDLE;
		end else begin
			q <= d;
		end
	end

	assign bus.scl_m_oe = q.scl_oe;
	assign bus.sda_m_oe = q.sda_oe;
	assign cmd_ready_o  = (q.st == M_IDLE);
	assign done_o       = q.done;
	assign rd_data_o    = q.rdd;
	assign ack_seen_o   = q.acks;
endmodule : twi_master
`default_nettype wire

// file: twi_monitor.sv
// Bus-level checks on the shared two-wire link
`timescale 1ns/100ps
`default_nettype none
module twi_monitor
	import twi_pkg::*;
	#(parameter logic [2:0] SEL = 3'h0)
	(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic scl_m_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic scl_s_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q, sda_q, first_q, sel_q, rd_q, quiet_q;
	logic [3:0] nb_q;
	logic [7:0] sh_q;
	logic       rise, cond, hit, ack;
	assign rise = scl && !scl_q;
	assign cond = scl && scl_q && (sda != sda_q);
	assign hit  = sh_q[7:4] == TYPE_CODE && sh_q[3:1] == SEL;
	assign ack  = rise && nb_q == ACK_SLOT;
	// Tracks bit slot, control byte and whether the slave is addressed
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			{scl_q, sda_q, first_q, sel_q, rd_q, quiet_q} <= 6'h30;
			nb_q <= 4'h0;
			sh_q <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (cond) begin
				nb_q <= 4'h0;
				first_q <= !sda;
				sel_q <= 1'b0;
				quiet_q <= 1'b0;
			end else if (ack) begin
				nb_q <= 4'h0;
				first_q <= 1'b0;
				quiet_q <= quiet_q | (first_q ? !hit : rd_q && sda);
				if (first_q) begin
					sel_q <= hit;
					rd_q <= sh_q[0];
				end
			end else if (rise) begin
				nb_q <= nb_q + 4'h1;
				sh_q <= {sh_q[6:0], sda};
			end
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_no_slave_clock: assert property (!scl_s_oe)
		else $error("slave pulled clock");
	a_data_steady_high: assert property (scl && scl_q |-> $stable(sda_s_oe))
		else $error("slave moved data while clock high");
	a_ack_on_match: assert property (ack && first_q |-> sda_s_oe == hit)
		else $error("control byte answer wrong");
	a_ack_rx_bytes: assert property (ack && !first_q && sel_q && !rd_q |-> sda_s_oe)
		else $error("written byte not acknowledged");
	a_ack_held_high: assert property (rise && sda_s_oe |-> (sda_s_oe && !sda) [*4])
		else $error("low not held through clock high");
	a_read_nack_release: assert property (ack && !first_q && sel_q && rd_q |-> !sda_s_oe)
		else $error("slave drove master acknowledge slot");
	a_quiet_released: assert property (quiet_q |-> !sda_s_oe)
		else $error("slave drove while ignoring bus");
	a_rx_bits_free: assert property (rise && nb_q < ACK_SLOT && !(sel_q && rd_q && !first_q) |-> !sda_s_oe)
		else $error("slave drove a received bit");
	a_ack_then_release: assert property (ack && !first_q && sel_q && !rd_q |-> ##[1:160] !sda_s_oe)
		else $error("acknowledge not released");
	c_write_ack: cover property (ack && !first_q && sel_q && !rd_q && sda_s_oe);
	c_read_nack: cover property (ack && sel_q && rd_q && sda);
	c_mismatch: cover property (ack && first_q && !hit);
endmodule : twi_monitor
`default_nettype wire

// file: two_wire_slave_interface_tb_top.sv
// Bench joining master and slave ends over one bus
`timescale 1ns/100ps
`default_nettype none
module two_wire_slave_interface_tb_top;
	import twi_pkg::*;
	localparam logic [2:0] SEL = 3'h5;
	logic clk_i = 1'b0, reset_i = 1'b1, fast_i = 1'b0, valid = 1'b0;
	logic c_start = 1'b0, c_stop = 1'b0, c_read = 1'b0, c_ack = 1'b0;
	logic [7:0] c_data = 8'h00, tx_data = 8'h00, rd_data, rx_data;
	logic cmd_ready, done, ack_seen, rx_valid, start_p, stop_p, read_mode, take_p;
	int err_total = 0, samples_checked = 0, rxs = 0, starts = 0, stops = 0, cycles = 0, takes = 0;
	twi_if bus_if();
	twi_master u_twi_master(.clk_i(clk_i), .reset_i(reset_i), .fast_i(fast_i), .cmd_valid_i(valid),
		.cmd_start_i(c_start), .cmd_stop_i(c_stop), .cmd_read_i(c_read), .cmd_ack_i(c_ack),
		.cmd_data_i(c_data), .cmd_ready_o(cmd_ready), .done_o(done), .rd_data_o(rd_data),
		.ack_seen_o(ack_seen), .bus(bus_if.master));
	twi_slave u_twi_slave(.clk_i(clk_i), .reset_i(reset_i), .select_strap_high_i(SEL[2]),
		.select_strap_mid_i(SEL[1]), .select_strap_low_i(SEL[0]), .tx_data_i(tx_data), .tx_take_o(take_p),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid), .start_o(start_p), .stop_o(stop_p),
		.read_mode_o(read_mode), .bus(bus_if.slave));
	twi_monitor #(.SEL(SEL)) u_twi_monitor(.clk_i(clk_i), .reset_i(reset_i), .scl_m_oe(bus_if.scl_m_oe),
		.sda_m_oe(bus_if.sda_m_oe), .sda_s_oe(bus_if.sda_s_oe), .scl_s_oe(bus_if.scl_s_oe),
		.scl(bus_if.scl), .sda(bus_if.sda));
	// Clock, pulse counters and hang guard
	always #25 clk_i = ~clk_i;
	always @(negedge clk_i) begin
		rxs += (rx_valid === 1'b1);
		starts += (start_p === 1'b1);
		stops += (stop_p === 1'b1);
		takes += (take_p === 1'b1);
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			summarize();
		end
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	// One byte command, then its acknowledge
	task xfer(input logic s, p, r, a, input logic [7:0] d, input logic e);
		int n;
		{c_start, c_stop, c_read, c_ack, c_data} = {s, p, r, a, d};
		valid = 1'b1;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 99) begin
			@(negedge clk_i);
			n++;
		end
		if (cmd_ready !== 1'b1)
			err_total++;
		@(negedge clk_i);
		valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 4000) begin
			@(negedge clk_i);
			n++;
		end
		if (done !== 1'b1)
			err_total++;
		repeat (8) @(negedge clk_i);
		chk(8'(ack_seen), 8'(e));
	endtask : xfer
	task summarize;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	// Main sequence
	initial begin
		repeat (8) @(negedge clk_i);
		reset_i = 1'b0;
		repeat (4) @(negedge clk_i);
		xfer(1, 0, 0, 0, {TYPE_CODE, SEL, 1'b0}, 1);
		chk(8'(read_mode), 8'h00);
		xfer(0, 0, 0, 0, 8'hA5, 1);
		chk(rx_data, 8'hA5);
		xfer(0, 1, 0, 0, 8'h3C, 1);
		chk(rx_data, 8'h3C);
		fast_i = 1'b1;
		tx_data = 8'h96;
		xfer(1, 0, 0, 0, {TYPE_CODE, SEL, 1'b1}, 1);
		chk(8'(read_mode), 8'h01);
		tx_data = 8'h5A;
		xfer(0, 0, 1, 1, 8'h00, 1);
		chk(rd_data, 8'h96);
		xfer(0, 1, 1, 0, 8'h00, 0);
		chk(rd_data, 8'h5A);
		xfer(1, 0, 0, 0, {TYPE_CODE, ~SEL, 1'b0}, 0);
		xfer(0, 1, 0, 0, 8'h77, 0);
		chk(8'(rxs), 8'h02);
		xfer(1, 0, 0, 0, {~TYPE_CODE, SEL, 1'b0}, 0);
		xfer(1, 0, 0, 0, {TYPE_CODE, SEL, 1'b0}, 1);
		tx_data = 8'hC3;
		xfer(1, 0, 0, 0, {TYPE_CODE, SEL, 1'b1}, 1);
		xfer(0, 1, 1, 0, 8'h00, 0);
		chk(rd_data, 8'hC3);
		chk(8'(takes), 8'h03);
		chk(8'(starts), 8'h06);
		chk(8'(stops), 8'h04);
		summarize();
	end
endmodule : two_wire_slave_interface_tb_top
`default_nettype wire
